// ---- mdimc_pkg.sv ----
package mdimc_pkg;

  // ------------------------------------------------------------
  // Widths of the command/address bus
  // ------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;

  // ------------------------------------------------------------
  // Command codes: {row strobe, column strobe, write enable}
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_TERMINATE = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ------------------------------------------------------------
  // Bank select targets of a mode load
  // ------------------------------------------------------------
  localparam logic [1:0] BANK_BASE_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT_MODE = 2'h2;

  // ------------------------------------------------------------
  // Field positions and encodings of the base mode word, plus the precharge-all address bit and init refresh count
  // ------------------------------------------------------------
  localparam int PRECHARGE_ALL_BIT = 10;
  localparam int BL_LSB = 0;
  localparam int TYPE_BIT = 3;
  localparam int CL_LSB = 4;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_3 = 3'h3;
  localparam int INIT_REFRESHES = 2;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [12:0] MODE_RESET = 13'h0000;
  localparam logic [1:0] REFRESH_COUNT_RESET = 2'h0;
  localparam logic [2:0] BEAT_RESET = 3'h0;
  localparam logic [1:0] WAIT_RESET = 2'h0;

  // ------------------------------------------------------------
  // Carriers and states
  // ------------------------------------------------------------
  typedef struct packed {
    logic chipSelectN;
    logic rowStrobeN;
    logic colStrobeN;
    logic writeEnableN;
  } mdimc_cmd_t;

  typedef struct packed {
    logic ready;
    logic burstIdle;
    logic protocolError;
  } mdimc_status_t;

  typedef enum {ST_POWER_UP, ST_PRECHARGED, ST_READY} mdimc_init_t;
  typedef enum {BU_IDLE, BU_LATENCY, BU_DATA} mdimc_burst_t;

endpackage

// ---- mdimc_burst_col.sv ----
module mdimc_burst_col
  import mdimc_pkg::*;
#(
  parameter int COL_W = 10
) (
  input wire logic [COL_W-1:0] startColumn,
  input wire logic [2:0] beatIndex,
  input wire logic [1:0] lengthLog2,
  input wire logic interleaved,
  output logic [COL_W-1:0] column
);

  logic [2:0] lowMask;
  logic [2:0] lowBits;

  // The burst stays inside its block: only the bits below the length move.
  always_comb begin
    lowMask = 3'((4'h1 << lengthLog2) - 4'h1);
    if (interleaved) begin
      lowBits = startColumn[2:0] ^ beatIndex;
    end else begin
      lowBits = 3'(startColumn[2:0] + beatIndex);
    end
    column = {startColumn[COL_W-1:3], (startColumn[2:0] & ~lowMask) | (lowBits & lowMask)};
  end

endmodule

// ---- mdimc_device.sv ----
// What this block does
// - Both mode registers start undefined and must be programmed during initialization.
// - Clock stopping is not allowed until initialization has completed.
// - After the full sequence the device accepts any valid command.
// - A mode load with both bank select bits zero targets the base register.
// - Base mode contents hold until reprogrammed, deep power down or power loss.
// - Mode load takes burst length from A0-A2, type A3, latency A4-A6.
// - Burst lengths two, four and eight, sequential and interleaved.
// - A burst accesses one block of burst length columns, wrapping inside it.
// - Upper column bits select the block, lower bits the starting column.
// - One programmed burst length serves reads and writes alike.
// - Read latency is two or three clocks; first read beat after that many.
// - Beat order follows burst length, burst type and starting column.
module mdimc_device
  import mdimc_pkg::*;
#(
  parameter int COL_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic linkClock,
  input wire logic clockEnable,
  input wire mdimc_cmd_t command,
  input wire logic bankSelectLow,
  input wire logic bankSelectHigh,
  input wire logic [ADDR_W-1:0] address,
  output logic [COL_W-1:0] columnAddress,
  output logic columnValid,
  output logic columnWrite,
  output logic readyForCommands,
  output logic clockStopAllowed,
  output logic protocolError,
  output logic [ADDR_W-1:0] baseModeConfig,
  output logic [3:0] burstLength,
  output logic interleavedBurst,
  output logic [1:0] readLatency
);

  // ------------------------------------------------------------
  // Reset into the link domain
  // ------------------------------------------------------------
  // The link clock may stop outside use, so reset is taken across by two flops.
  logic linkRstMeta;
  logic linkRst;

  always_ff @(posedge linkClock) begin
    linkRstMeta <= rst;
    linkRst <= linkRstMeta;
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic isCmd;
  logic [2:0] cmdCode;
  logic [1:0] bankSel;
  logic deepPowerDown;

  always_comb begin
    isCmd = clockEnable && !command.chipSelectN;
    cmdCode = {command.rowStrobeN, command.colStrobeN, command.writeEnableN};
    bankSel = {bankSelectHigh, bankSelectLow};
    deepPowerDown = !clockEnable && !command.chipSelectN && (cmdCode == CMD_TERMINATE);
  end

  // ------------------------------------------------------------
  // Initialization tracking and mode register
  // ------------------------------------------------------------
  mdimc_init_t initState;
  mdimc_init_t next_initState;
  logic [1:0] refreshCount;
  logic [1:0] next_refreshCount;
  logic baseLoaded;
  logic next_baseLoaded;
  logic extLoaded;
  logic next_extLoaded;
  logic [ADDR_W-1:0] modeReg;
  logic [ADDR_W-1:0] next_modeReg;
  logic modeToggle;
  logic next_modeToggle;
  logic linkError;
  logic next_linkError;
  logic rejectBurst;

  always_comb begin
    next_initState = initState;
    next_refreshCount = refreshCount;
    next_baseLoaded = baseLoaded;
    next_extLoaded = extLoaded;
    next_modeReg = modeReg;
    next_modeToggle = modeToggle;
    next_linkError = linkError || rejectBurst;
    if (deepPowerDown) begin
      // Deep power down loses the mode word and needs a fresh init.
      next_initState = ST_POWER_UP;
      next_refreshCount = REFRESH_COUNT_RESET;
      next_baseLoaded = 1'b0;
      next_extLoaded = 1'b0;
      next_modeReg = MODE_RESET;
      next_modeToggle = !modeToggle;
    end else if (isCmd && cmdCode == CMD_MODE_LOAD && bankSel == BANK_BASE_MODE) begin
      next_modeReg = address;
      next_modeToggle = !modeToggle;
      next_baseLoaded = 1'b1;
    end else if (isCmd && cmdCode == CMD_MODE_LOAD && bankSel == BANK_EXT_MODE) begin
      next_extLoaded = 1'b1;
    end
    unique case (initState)
      ST_POWER_UP: begin
        if (isCmd && cmdCode == CMD_PRECHARGE && address[PRECHARGE_ALL_BIT] && !deepPowerDown) begin
          next_initState = ST_PRECHARGED;
        end else if (isCmd && cmdCode != CMD_NOP) begin
          next_linkError = 1'b1;
        end
      end
      ST_PRECHARGED: begin
        if (deepPowerDown) begin
          next_initState = ST_POWER_UP;
        end else if (isCmd && cmdCode == CMD_REFRESH) begin
          // Refreshes may fall before or after the mode loads.
          if (refreshCount == 2'(INIT_REFRESHES)) begin
            next_linkError = 1'b1;
          end else begin
            next_refreshCount = 2'(refreshCount + 2'h1);
          end
        end else if (isCmd && !(cmdCode inside {CMD_NOP, CMD_PRECHARGE, CMD_MODE_LOAD})) begin
          next_linkError = 1'b1;
        end
        if (next_refreshCount == 2'(INIT_REFRESHES) && next_baseLoaded && next_extLoaded
            && !deepPowerDown) begin
          next_initState = ST_READY;
        end
      end
      ST_READY: begin
        if (deepPowerDown) begin
          next_initState = ST_POWER_UP;
        end
      end
    endcase
  end

  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      initState <= ST_POWER_UP;
      refreshCount <= REFRESH_COUNT_RESET;
      baseLoaded <= 1'b0;
      extLoaded <= 1'b0;
      modeReg <= MODE_RESET;
      modeToggle <= 1'b0;
      linkError <= 1'b0;
    end else begin
      initState <= next_initState;
      refreshCount <= next_refreshCount;
      baseLoaded <= next_baseLoaded;
      extLoaded <= next_extLoaded;
      modeReg <= next_modeReg;
      modeToggle <= next_modeToggle;
      linkError <= next_linkError;
    end
  end

  // ------------------------------------------------------------
  // Mode word fields as used by the burst engine
  // ------------------------------------------------------------
  logic [1:0] lengthLog2;
  logic lengthValid;
  logic [1:0] latencyWait;

  always_comb begin
    // One length for reads and writes.
    unique case (modeReg[BL_LSB +: 3])
      BL_CODE_2: lengthLog2 = 2'h1;
      BL_CODE_4: lengthLog2 = 2'h2;
      BL_CODE_8: lengthLog2 = 2'h3;
      default: lengthLog2 = 2'h0;
    endcase
    lengthValid = lengthLog2 != 2'h0;
    // A reserved latency code falls back to the longer latency.
    latencyWait = (modeReg[CL_LSB +: 3] == CL_CODE_2) ? 2'h1 : 2'h2;
  end

  // ------------------------------------------------------------
  // Burst engine
  // ------------------------------------------------------------
  mdimc_burst_t burstState;
  mdimc_burst_t next_burstState;
  logic [COL_W-1:0] startCol;
  logic [COL_W-1:0] next_startCol;
  logic [2:0] beat;
  logic [2:0] next_beat;
  logic [1:0] waitCount;
  logic [1:0] next_waitCount;
  logic isWrite;
  logic next_isWrite;
  logic [COL_W-1:0] colOut;
  logic [COL_W-1:0] next_colOut;
  logic colValid;
  logic next_colValid;
  logic [COL_W-1:0] orderedCol;
  logic [2:0] lastBeat;
  logic burstCmd;

  mdimc_burst_col #(
    .COL_W(COL_W)
  ) u_order (
    .startColumn(startCol),
    .beatIndex(beat),
    .lengthLog2(lengthLog2),
    .interleaved(modeReg[TYPE_BIT]),
    .column(orderedCol)
  );

  always_comb begin
    burstCmd = isCmd && initState == ST_READY && (cmdCode == CMD_READ || cmdCode == CMD_WRITE);
    rejectBurst = burstCmd && !lengthValid;
    lastBeat = 3'((4'h1 << lengthLog2) - 4'h1);
    next_burstState = burstState;
    next_startCol = startCol;
    next_beat = beat;
    next_waitCount = waitCount;
    next_isWrite = isWrite;
    next_colOut = colOut;
    next_colValid = 1'b0;
    unique case (burstState)
      BU_IDLE: ;
      BU_LATENCY: begin
        if (waitCount == 2'h0) begin
          next_colOut = orderedCol;
          next_colValid = 1'b1;
          next_beat = 3'h1;
          next_burstState = BU_DATA;
        end else begin
          next_waitCount = 2'(waitCount - 2'h1);
        end
      end
      BU_DATA: begin
        next_colOut = orderedCol;
        next_colValid = 1'b1;
        next_beat = 3'(beat + 3'h1);
        if (beat == lastBeat) begin
          next_burstState = BU_IDLE;
        end
      end
    endcase
    // A new read or write cuts off whatever burst is running.
    if (burstCmd && lengthValid) begin
      next_burstState = BU_LATENCY;
      next_startCol = address[COL_W-1:0];
      next_beat = BEAT_RESET;
      next_isWrite = cmdCode == CMD_WRITE;
      next_waitCount = (cmdCode == CMD_WRITE) ? WAIT_RESET : latencyWait;
    end
    if (deepPowerDown) begin
      next_burstState = BU_IDLE;
    end
  end

  always_ff @(posedge linkClock) begin
    if (linkRst) begin
      burstState <= BU_IDLE;
      startCol <= '0;
      beat <= BEAT_RESET;
      waitCount <= WAIT_RESET;
      isWrite <= 1'b0;
      colOut <= '0;
      colValid <= 1'b0;
    end else begin
      burstState <= next_burstState;
      startCol <= next_startCol;
      beat <= next_beat;
      waitCount <= next_waitCount;
      isWrite <= next_isWrite;
      colOut <= next_colOut;
      colValid <= next_colValid;
    end
  end

  always_comb begin
    columnAddress = colOut;
    columnValid = colValid;
    columnWrite = isWrite;
  end

  // ------------------------------------------------------------
  // Crossing into the system clock domain
  // ------------------------------------------------------------
  // The mode word is held for at least a mode load delay of link clocks,
  // far longer than the three system clocks the toggle takes to cross.
  mdimc_status_t linkStatus;
  mdimc_status_t statusMeta;
  mdimc_status_t statusSync;
  logic toggleMeta;
  logic toggleSync;
  logic toggleSeen;
  logic [ADDR_W-1:0] modeCopy;
  logic [ADDR_W-1:0] next_modeCopy;
  logic [3:0] next_burstLength;
  logic next_interleaved;
  logic [1:0] next_readLatency;

  always_comb begin
    linkStatus.ready = initState == ST_READY;
    // The last beat is still on the bus after the state machine has gone idle.
    linkStatus.burstIdle = burstState == BU_IDLE && !colValid;
    linkStatus.protocolError = linkError;
  end

  always_comb begin
    next_modeCopy = (toggleSync != toggleSeen) ? modeReg : modeCopy;
    unique case (next_modeCopy[BL_LSB +: 3])
      BL_CODE_2: next_burstLength = 4'h2;
      BL_CODE_4: next_burstLength = 4'h4;
      BL_CODE_8: next_burstLength = 4'h8;
      default: next_burstLength = 4'h0;
    endcase
    next_interleaved = next_modeCopy[TYPE_BIT];
    next_readLatency = (next_modeCopy[CL_LSB +: 3] == CL_CODE_2) ? 2'h2 : 2'h3;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      statusMeta <= '0;
      statusSync <= '0;
      toggleMeta <= 1'b0;
      toggleSync <= 1'b0;
      toggleSeen <= 1'b0;
      modeCopy <= MODE_RESET;
      burstLength <= 4'h0;
      interleavedBurst <= 1'b0;
      readLatency <= 2'h3;
    end else begin
      statusMeta <= linkStatus;
      statusSync <= statusMeta;
      toggleMeta <= modeToggle;
      toggleSync <= toggleMeta;
      toggleSeen <= toggleSync;
      modeCopy <= next_modeCopy;
      burstLength <= next_burstLength;
      interleavedBurst <= next_interleaved;
      readLatency <= next_readLatency;
    end
  end

  always_comb begin
    readyForCommands = statusSync.ready;
    clockStopAllowed = statusSync.ready && statusSync.burstIdle;
    protocolError = statusSync.protocolError;
    baseModeConfig = modeCopy;
  end

endmodule

// ---- mdimc_ctrl_model.sv ----
module mdimc_ctrl_model
  import mdimc_pkg::*;
#(
  parameter int STARTUP_CLKS = 2500,
  parameter int PRECHARGE_WAIT = 2,
  parameter int REFRESH_WAIT = 8,
  parameter int MODE_WAIT = 2
) (
  input wire logic linkClock,
  output logic clockEnable,
  output mdimc_cmd_t command,
  output logic bankSelectLow,
  output logic bankSelectHigh,
  output logic [ADDR_W-1:0] address
);
  // ------------------------------------------------------------
  // Command bus driver
  // ------------------------------------------------------------
  initial begin
    clockEnable = 1'b1;
    command = {1'b0, CMD_NOP};
    {bankSelectHigh, bankSelectLow} = 2'h0;
    address = 13'h0000;
  end

  // Idle cycles invert the address so nothing can lean on a stale value.
  task automatic nops(input int n);
    repeat (n) begin
      @(posedge linkClock);
      command <= {1'b0, CMD_NOP};
      address <= ~address;
    end
  endtask

  task automatic issue(input logic [2:0] code, input logic [1:0] bank, input logic [12:0] a);
    @(posedge linkClock);
    command <= {1'b0, code};
    {bankSelectHigh, bankSelectLow} <= bank;
    address <= a;
    nops(1);
  endtask

  task automatic refreshes();
    repeat (INIT_REFRESHES) begin
      issue(CMD_REFRESH, 2'h0, 13'h0000);
      nops(REFRESH_WAIT);
    end
  endtask

  task automatic init_head(input logic [12:0] word, input bit late);
    nops(STARTUP_CLKS);
    issue(CMD_PRECHARGE, 2'h0, 13'h0400);
    nops(PRECHARGE_WAIT);
    if (!late) begin
      refreshes();
    end
    issue(CMD_MODE_LOAD, BANK_BASE_MODE, word);
    nops(MODE_WAIT);
  endtask

  task automatic init_tail(input bit late);
    issue(CMD_MODE_LOAD, BANK_EXT_MODE, 13'h0000);
    nops(MODE_WAIT);
    if (late) begin
      refreshes();
    end
  endtask

  // Clock enable only drops for deep power down, never to stop the clock.
  task automatic power_down();
    @(posedge linkClock);
    clockEnable <= 1'b0;
    command <= {1'b0, CMD_TERMINATE};
    nops(3);
    clockEnable <= 1'b1;
    nops(2);
  endtask
endmodule

// ---- mdimc_device_chk.sv ----
module mdimc_device_chk
  import mdimc_pkg::*;
#(
  parameter int COL_W = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic linkClock,
  input wire logic clockEnable,
  input wire mdimc_cmd_t command,
  input wire logic bankSelectLow,
  input wire logic bankSelectHigh,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [COL_W-1:0] columnAddress,
  input wire logic columnValid,
  input wire logic columnWrite,
  input wire logic readyForCommands,
  input wire logic clockStopAllowed,
  input wire logic protocolError,
  input wire logic [ADDR_W-1:0] baseModeConfig,
  input wire logic [3:0] burstLength,
  input wire logic interleavedBurst,
  input wire logic [1:0] readLatency
);
  // ------------------------------------------------------------
  // Reset as the link logic sees it
  // ------------------------------------------------------------
  // Link checks follow the same two-flop delay as the device's own link reset.
  logic linkRstMeta;
  logic linkRst;

  always_ff @(posedge linkClock) begin
    linkRstMeta <= rst;
    linkRst <= linkRstMeta;
  end

  // ------------------------------------------------------------
  // Beat tracking
  // ------------------------------------------------------------
  logic [3:0] beatRun;
  logic [3:0] next_beatRun;
  logic [COL_W-1:0] startCol;
  logic [COL_W-1:0] next_startCol;
  logic [COL_W-1:0] mask;
  logic [COL_W-1:0] offset;

  always_comb begin
    mask = COL_W'(burstLength) - 1'b1;
    offset = interleavedBurst ? columnAddress ^ startCol : columnAddress - startCol;
    next_beatRun = columnValid ? beatRun + 4'h1 : 4'h0;
    next_startCol = (columnValid && beatRun == 4'h0) ? columnAddress : startCol;
  end

  always_ff @(posedge linkClock) begin
    beatRun <= linkRst ? 4'h0 : next_beatRun;
    startCol <= next_startCol;
  end

  sequence taken(logic [2:0] code);
    clockEnable && command == {1'b0, code};
  endsequence

  sequence burst_go(logic [2:0] code);
    taken(code) ##0 (readyForCommands && burstLength != 4'h0);
  endsequence

  wr_latency_a: assert property (@(posedge linkClock) disable iff (linkRst)
    burst_go(CMD_WRITE) |-> ##1 !columnValid ##1 (columnValid && columnWrite))
    else $error("write burst start misplaced");
  rd_latency_a: assert property (@(posedge linkClock) disable iff (linkRst)
    burst_go(CMD_READ) ##0 readLatency == 2'h3 |-> ##3 !columnValid ##1 columnValid)
    else $error("read burst start misplaced");
  beat_count_a: assert property (@(posedge linkClock) disable iff (linkRst)
    $fell(columnValid) |-> beatRun == burstLength)
    else $error("beat count differs from length");
  beat_order_a: assert property (@(posedge linkClock) disable iff (linkRst)
    columnValid && beatRun != 4'h0 |-> (offset & mask) == COL_W'(beatRun))
    else $error("beat column out of order");
  block_keep_a: assert property (@(posedge linkClock) disable iff (linkRst)
    columnValid && beatRun != 4'h0 |-> (columnAddress & ~mask) == (startCol & ~mask))
    else $error("burst left its block");
  base_load_a: assert property (@(posedge linkClock) disable iff (linkRst)
    taken(CMD_MODE_LOAD) ##0 (readyForCommands && !bankSelectLow && !bankSelectHigh)
    |=> baseModeConfig == $past(address))
    else $error("mode word not stored");
  dpd_clear_a: assert property (@(posedge linkClock) disable iff (linkRst)
    !clockEnable && command == {1'b0, CMD_TERMINATE}
    |=> baseModeConfig == MODE_RESET && !readyForCommands)
    else $error("deep power down kept state");
  early_cmd_a: assert property (@(posedge linkClock) disable iff (linkRst)
    taken(CMD_READ) ##0 !readyForCommands |=> protocolError)
    else $error("early read not flagged");
  bl_decode_a: assert property (@(posedge clock) disable iff (rst)
    burstLength == (baseModeConfig[2:0] == BL_CODE_2 ? 4'h2 :
      baseModeConfig[2:0] == BL_CODE_4 ? 4'h4 : baseModeConfig[2:0] == BL_CODE_8 ? 4'h8 : 4'h0))
    else $error("burst length decode wrong");
  cl_decode_a: assert property (@(posedge clock) disable iff (rst)
    readLatency == (baseModeConfig[6:4] == CL_CODE_2 ? 2'h2 : 2'h3)
    && interleavedBurst == baseModeConfig[TYPE_BIT])
    else $error("latency or type decode wrong");
  stop_ready_a: assert property (@(posedge clock) disable iff (rst)
    clockStopAllowed |-> readyForCommands)
    else $error("clock stop before ready");
endmodule

bind mdimc_device mdimc_device_chk #(.COL_W(COL_W)) mdimc_device_chk_i (
  .clock(clock), .rst(rst), .linkClock(linkClock), .clockEnable(clockEnable),
  .command(command), .bankSelectLow(bankSelectLow), .bankSelectHigh(bankSelectHigh),
  .address(address), .columnAddress(columnAddress), .columnValid(columnValid),
  .columnWrite(columnWrite), .readyForCommands(readyForCommands),
  .clockStopAllowed(clockStopAllowed), .protocolError(protocolError),
  .baseModeConfig(baseModeConfig), .burstLength(burstLength),
  .interleavedBurst(interleavedBurst), .readLatency(readLatency)
);

// ---- mdimc_device_tb.sv ----
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin errTotal++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module mdimc_device_tb
  import mdimc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic linkClock = 1'b0;
  logic rst = 1'b1;
  int errTotal = 0;
  int totalChecks = 0;
  logic clockEnable, bankSelectLow, bankSelectHigh, columnValid, columnWrite;
  logic readyForCommands, clockStopAllowed, protocolError, interleavedBurst;
  mdimc_cmd_t command;
  logic [ADDR_W-1:0] address, baseModeConfig;
  logic [9:0] columnAddress;
  logic [3:0] burstLength;
  logic [1:0] readLatency;

  always #5 clock = ~clock;
  initial #3 forever #40 linkClock = ~linkClock;

  mdimc_device mdimc_device_i (.clock(clock), .rst(rst), .linkClock(linkClock),
    .clockEnable(clockEnable), .command(command), .bankSelectLow(bankSelectLow),
    .bankSelectHigh(bankSelectHigh), .address(address), .columnAddress(columnAddress),
    .columnValid(columnValid), .columnWrite(columnWrite),
    .readyForCommands(readyForCommands), .clockStopAllowed(clockStopAllowed),
    .protocolError(protocolError), .baseModeConfig(baseModeConfig),
    .burstLength(burstLength), .interleavedBurst(interleavedBurst),
    .readLatency(readLatency));
  mdimc_ctrl_model mdimc_ctrl_model_i (.linkClock(linkClock), .clockEnable(clockEnable),
    .command(command), .bankSelectLow(bankSelectLow), .bankSelectHigh(bankSelectHigh),
    .address(address));

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset is held long enough for the link side to see it through its synchroniser.
  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (40) @(posedge clock);
    @(negedge clock);
    `CHK("ready", 1'b0, readyForCommands)
    `CHK("stop", 1'b0, clockStopAllowed)
    `CHK("error", 1'b0, protocolError)
    `CHK("latency", 2'h3, readLatency)
    @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge linkClock);
  endtask

  task automatic t_init(input logic [12:0] word, input bit late);
    mdimc_ctrl_model_i.init_head(word, late);
    @(negedge clock);
    `CHK("ready early", 1'b0, readyForCommands)
    mdimc_ctrl_model_i.init_tail(late);
    @(negedge clock);
    `CHK("ready", 1'b1, readyForCommands)
    `CHK("stop", 1'b1, clockStopAllowed)
    `CHK("mode word", word, baseModeConfig)
    `CHK("error", 1'b0, protocolError)
  endtask

  task automatic t_burst(input int i);
    logic [12:0] word;
    logic [9:0] start, pos;
    int bl, k;
    bit il, wr;
    bl = 2 << (i / 2);
    il = i[0];
    wr = i[0] ^ i[1];
    start = 10'h2A4 + 10'(i * 3);
    word = {6'h00, il ? CL_CODE_3 : CL_CODE_2, il,
      i < 2 ? BL_CODE_2 : i < 4 ? BL_CODE_4 : BL_CODE_8};
    mdimc_ctrl_model_i.issue(CMD_MODE_LOAD, BANK_BASE_MODE, word);
    mdimc_ctrl_model_i.nops(2);
    @(negedge clock);
    `CHK("length", 4'(bl), burstLength)
    `CHK("type", il, interleavedBurst)
    `CHK("latency", 2'h2 + 2'(il), readLatency)
    mdimc_ctrl_model_i.issue(wr ? CMD_WRITE : CMD_READ, 2'h1, {3'h0, start});
    k = 0;
    @(negedge linkClock);
    while (!columnValid && k < 8) begin
      k++;
      @(negedge linkClock);
    end
    `CHK("first beat", wr ? 1 : 2 + il, k)
    for (int b = 0; b < bl; b++) begin
      pos = il ? (start ^ 10'(b)) : (start + 10'(b));
      `CHK("column", (start & ~10'(bl - 1)) | (pos & 10'(bl - 1)), columnAddress)
      `CHK("beat", 1'b1, columnValid)
      `CHK("write flag", wr, columnWrite)
      `CHK("stop busy", 1'b0, clockStopAllowed)
      @(negedge linkClock);
    end
    `CHK("burst end", 1'b0, columnValid)
  endtask

  task automatic t_dpd();
    mdimc_ctrl_model_i.power_down();
    @(negedge clock);
    `CHK("mode after sleep", MODE_RESET, baseModeConfig)
    `CHK("ready after sleep", 1'b0, readyForCommands)
    t_init(13'h0033, 1'b1);
  endtask

  task automatic t_reserved();
    logic seen;
    seen = 1'b0;
    mdimc_ctrl_model_i.issue(CMD_MODE_LOAD, BANK_BASE_MODE, 13'h0027);
    mdimc_ctrl_model_i.nops(2);
    @(negedge clock);
    `CHK("reserved length", 4'h0, burstLength)
    mdimc_ctrl_model_i.issue(CMD_READ, 2'h0, 13'h0000);
    repeat (8) begin
      @(negedge linkClock);
      seen |= columnValid;
    end
    `CHK("ignored read", 1'b0, seen)
    `CHK("error", 1'b1, protocolError)
  endtask

  task automatic t_early();
    do_reset();
    mdimc_ctrl_model_i.issue(CMD_READ, 2'h0, 13'h0000);
    mdimc_ctrl_model_i.nops(1);
    @(negedge clock);
    `CHK("early error", 1'b1, protocolError)
  endtask

  initial begin
    do_reset();
    t_init(13'h0022, 1'b0);
    for (int i = 0; i < 6; i++) begin
      t_burst(i);
    end
    t_dpd();
    t_reserved();
    t_early();
    report_and_stop();
  end

  // Two start-up waits of 200 us dominate the run; 1 ms leaves ample margin.
  initial begin
    #1000000;
    errTotal++;
    report_and_stop();
  end
endmodule
